// File: rtl/sfx_post_exc.sv
// Purpose: overflow, underflow and inexact response for packed/scalar simd fp results
// Assumes: pipeline supplies per-lane rounded result with unbounded exponent, plus the
//          bounded (denormalised) result and its inexact bit
// Notes: one cycle from in_valid to out_valid; double uses lanes 0 and 1
`timescale 1ns/1ps

// Operation
// - flag overflow when the rounded result exceeds the largest finite normal value.
// - masked overflow sets overflow and precision and returns infinity or max by mode.
// - unmasked overflow scales the result down by 2^192 or 2^1536, precision if inexact.
// - flag underflow when the unbounded rounded result is below the smallest normal value.
// - masked underflow returns the bounded result, underflow and precision only if inexact.
// - unmasked underflow scales the result up by 2^192 or 2^1536, precision if inexact.
// - detect inexact whenever the exact outcome is not representable.
// - masked inexact returns the bounded rounded result and sets precision.
// - precision may be raised together with masked overflow or masked underflow.
// - the inexact trap is taken only without unmasked overflow or underflow.
// - inexact trap with masked overflow also sets overflow and gives the masked result.
// - inexact trap with masked underflow also sets underflow and gives the masked result.
// - inexact trap alone gives the bounded rounded result and sets precision.
// - rounding direction comes from the control/status word rounding field.
// - any unmasked exception traps through vector 19.
module sfx_post_exc (
	input  wire logic                  core_clk,
	input  wire logic                  nrst,
	input  wire logic                  in_valid,
	input  wire logic                  is_double,
	input  wire logic [3:0]            lane_active,
	input  wire logic [3:0]            lane_special,
	input  wire logic [3:0]            lane_sign,
	input  wire logic [3:0][12:0]      lane_exp,
	input  wire logic [3:0][51:0]      lane_frac,
	input  wire logic [3:0]            lane_inexact,
	input  wire logic [3:0][63:0]      lane_bounded,
	input  wire logic [3:0]            lane_bounded_inexact,
	input  wire logic [31:0]           simd_fp_control_status_reg,
	output logic                       out_valid,
	output logic [127:0]               out_result,
	output logic                       overflow_flag,
	output logic                       underflow_flag,
	output logic                       precision_flag,
	output logic                       overflow_flag_trap,
	output logic                       underflow_trap,
	output logic                       precision_trap,
	output logic                       trap,
	output logic [7:0]                 trap_vector
);
	logic [1:0] rnd;
	logic       om;
	logic       um;
	logic       pm;
	logic [3:0][63:0] lres;
	logic [3:0] loe;
	logic [3:0] lue;
	logic [3:0] lpe;
	logic [3:0] lovf_trap;
	logic [3:0] lunf_trap;

	logic         next_valid;
	logic [127:0] next_result;
	logic         next_oe;
	logic         next_ue;
	logic         next_pe;
	logic         next_ot;
	logic         next_ut;
	logic         next_pt;
	logic         next_trap;
	logic [7:0]   next_vector;

	// control word fields
	assign rnd = simd_fp_control_status_reg[sfx_pkg::SFX_RC_LSB +: 2];
	assign om  = simd_fp_control_status_reg[sfx_pkg::SFX_OM_BIT];
	assign um  = simd_fp_control_status_reg[sfx_pkg::SFX_UM_BIT];
	assign pm  = simd_fp_control_status_reg[sfx_pkg::SFX_PM_BIT];

	for (genvar i = 0; i < sfx_pkg::SFX_LANES; i++) begin : g_lane
		logic signed [13:0] e;
		logic signed [13:0] emax;
		logic signed [13:0] emin;
		logic signed [13:0] bias;
		logic signed [13:0] adj;
		logic signed [13:0] bexp;
		logic               act;
		logic               ovf;
		logic               unf;
		logic               to_max;
		logic               s;
		logic [63:0]        maxf;
		logic [63:0]        inf;
		logic [63:0]        packed_res;
		// lane verdict
		logic [63:0]        l_res;
		logic               l_oe;
		logic               l_ue;
		logic               l_pe;
		logic               l_ot;
		logic               l_ut;

		always_comb begin
			s    = lane_sign[i];
			e    = {lane_exp[i][12], lane_exp[i]};
			emax = is_double ? sfx_pkg::SFX_EMAX_DP : sfx_pkg::SFX_EMAX_SP;
			emin = is_double ? sfx_pkg::SFX_EMIN_DP : sfx_pkg::SFX_EMIN_SP;
			bias = is_double ? sfx_pkg::SFX_BIAS_DP : sfx_pkg::SFX_BIAS_SP;
			adj  = is_double ? sfx_pkg::SFX_ADJ_DP : sfx_pkg::SFX_ADJ_SP;
			// double occupies only the two low lanes
			act  = lane_active[i] & ~lane_special[i] & ~(is_double & (i > 1));
			ovf  = act & (e > emax);
			unf  = act & (e < emin);
			// scaled exponent for the unmasked trap paths
			if (ovf) begin
				bexp = 14'(e - adj + bias);
			end else if (unf) begin
				bexp = 14'(e + adj + bias);
			end else begin
				bexp = 14'(e + bias);
			end
			to_max = (rnd == sfx_pkg::SFX_RND_ZERO) | ((rnd == sfx_pkg::SFX_RND_DOWN) & ~s)
				| ((rnd == sfx_pkg::SFX_RND_UP) & s);
			if (is_double) begin
				maxf       = {s, sfx_pkg::SFX_EXP_MAXF_DP, sfx_pkg::SFX_FRAC_ONES};
				inf        = {s, sfx_pkg::SFX_EXP_INF_DP, 52'h0_0000_0000_0000};
				packed_res = {s, bexp[10:0], lane_frac[i]};
			end else begin
				maxf       = {32'h0000_0000, s, sfx_pkg::SFX_EXP_MAXF_SP,
					sfx_pkg::SFX_FRAC_ONES[51:29]};
				inf        = {32'h0000_0000, s, sfx_pkg::SFX_EXP_INF_SP, 23'h00_0000};
				packed_res = {32'h0000_0000, s, bexp[7:0], lane_frac[i][51:29]};
			end
			l_ot = ovf & ~om;
			l_ut = unf & ~um;
			l_oe = ovf;
			if (ovf & om) begin
				l_res = to_max ? maxf : inf;
				l_ue  = 1'b0;
				l_pe  = 1'b1;
			end else if (ovf) begin
				l_res = packed_res;
				l_ue  = 1'b0;
				l_pe  = lane_inexact[i];
			end else if (unf & um) begin
				l_res = lane_bounded[i];
				l_ue  = lane_bounded_inexact[i];
				l_pe  = lane_bounded_inexact[i];
			end else if (unf) begin
				l_res = packed_res;
				l_ue  = 1'b1;
				l_pe  = lane_inexact[i];
			end else if (act) begin
				l_res = packed_res;
				l_ue  = 1'b0;
				l_pe  = lane_inexact[i];
			end else begin
				// special, inactive or unused lane passes the bounded value through
				l_res = lane_bounded[i];
				l_ue  = 1'b0;
				l_pe  = lane_active[i] & lane_bounded_inexact[i]
					& ~(is_double & (i > 1));
			end
		end

		// one driver per lane slice of the shared vectors
		assign lres[i]      = l_res;
		assign loe[i]       = l_oe;
		assign lue[i]       = l_ue;
		assign lpe[i]       = l_pe;
		assign lovf_trap[i] = l_ot;
		assign lunf_trap[i] = l_ut;
	end

	always_comb begin
		next_valid = in_valid;
		if (is_double) begin
			next_result = {lres[1], lres[0]};
		end else begin
			next_result = {lres[3][31:0], lres[2][31:0], lres[1][31:0], lres[0][31:0]};
		end
		next_oe = in_valid & (|loe);
		next_ue = in_valid & (|lue);
		next_pe = in_valid & (|lpe);
		next_ot = in_valid & (|lovf_trap);
		next_ut = in_valid & (|lunf_trap);
		// inexact trap only without unmasked overflow or underflow anywhere
		next_pt = in_valid & (|lpe) & ~pm & ~(|lovf_trap) & ~(|lunf_trap);
		next_trap = next_ot | next_ut | next_pt;
		// vector only while some cause is unmasked
		if (next_trap) begin
			next_vector = sfx_pkg::SFX_TRAP_VECTOR;
		end else begin
			next_vector = 8'h00;
		end
	end

	// every output leaves from a flop
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			// all outputs idle while reset is held
			out_valid          <= 1'b0;
			out_result         <= '0;
			overflow_flag      <= 1'b0;
			underflow_flag     <= 1'b0;
			precision_flag     <= 1'b0;
			overflow_flag_trap <= 1'b0;
			underflow_trap     <= 1'b0;
			precision_trap     <= 1'b0;
			trap               <= 1'b0;
			trap_vector        <= 8'h00;
		end else begin
			out_valid          <= next_valid;
			out_result         <= next_result;
			overflow_flag      <= next_oe;
			underflow_flag     <= next_ue;
			precision_flag     <= next_pe;
			overflow_flag_trap <= next_ot;
			underflow_trap     <= next_ut;
			precision_trap     <= next_pt;
			trap               <= next_trap;
			trap_vector        <= next_vector;
		end
	end
endmodule : sfx_post_exc

// File: rtl/sfx_pkg.sv
// Purpose: constants for the simd fp post-computation exception unit
// Assumes: control/status word layout with flags in [5:0], masks in [12:7], rounding in [14:13]
// Notes: exponents are unbiased, carried as 14-bit signed values
package sfx_pkg;
	// control/status word fields
	localparam int SFX_OE_FLAG_BIT = 3;
	localparam int SFX_UE_FLAG_BIT = 4;
	localparam int SFX_PE_FLAG_BIT = 5;
	localparam int SFX_OM_BIT      = 10;
	localparam int SFX_UM_BIT      = 11;
	localparam int SFX_PM_BIT      = 12;
	localparam int SFX_RC_LSB      = 13;

	// rounding direction codes
	localparam logic [1:0] SFX_RND_NEAR = 2'h0;
	localparam logic [1:0] SFX_RND_DOWN = 2'h1;
	localparam logic [1:0] SFX_RND_UP   = 2'h2;
	localparam logic [1:0] SFX_RND_ZERO = 2'h3;

	// exponent limits, biases and trap scaling
	localparam logic signed [13:0] SFX_EMAX_SP = 14'sh007F;
	localparam logic signed [13:0] SFX_EMAX_DP = 14'sh03FF;
	localparam logic signed [13:0] SFX_EMIN_SP = -14'sh007E;
	localparam logic signed [13:0] SFX_EMIN_DP = -14'sh03FE;
	localparam logic signed [13:0] SFX_BIAS_SP = 14'sh007F;
	localparam logic signed [13:0] SFX_BIAS_DP = 14'sh03FF;
	localparam logic signed [13:0] SFX_ADJ_SP  = 14'sh00C0;
	localparam logic signed [13:0] SFX_ADJ_DP  = 14'sh0600;

	// special encodings
	localparam logic [7:0]  SFX_EXP_MAXF_SP = 8'hFE;
	localparam logic [10:0] SFX_EXP_MAXF_DP = 11'h7FE;
	localparam logic [7:0]  SFX_EXP_INF_SP  = 8'hFF;
	localparam logic [10:0] SFX_EXP_INF_DP  = 11'h7FF;
	localparam logic [51:0] SFX_FRAC_ONES   = 52'hF_FFFF_FFFF_FFFF;

	localparam logic [7:0]  SFX_TRAP_VECTOR = 8'h13;
	localparam int          SFX_LANES       = 4;
endpackage : sfx_pkg

// File: dv/sfx_post_exc_asserts.sv
// Purpose: port checks for sfx_post_exc
// Assumes: one-cycle latency, masks at control bits 10..12
// Notes: bound to every sfx_post_exc instance
`timescale 1ns/1ps
module sfx_post_exc_asserts (
	input wire logic        core_clk,
	input wire logic        nrst,
	input wire logic        in_valid,
	input wire logic [31:0] simd_fp_control_status_reg,
	input wire logic        out_valid,
	input wire logic        overflow_flag,
	input wire logic        underflow_flag,
	input wire logic        precision_flag,
	input wire logic        overflow_flag_trap,
	input wire logic        underflow_trap,
	input wire logic        precision_trap,
	input wire logic        trap,
	input wire logic [7:0]  trap_vector
);
	default clocking dc @(posedge core_clk); endclocking
	default disable iff (!nrst);
	property p_lat; in_valid |=> out_valid; endproperty
	a_lat: assert property (p_lat) else $error("answer missing");
	property p_idle;
		!in_valid |=> !(out_valid | overflow_flag | underflow_flag | precision_flag);
	endproperty
	a_idle: assert property (p_idle) else $error("flags without request");
	property p_vec; trap_vector == (trap ? 8'h13 : 8'h00); endproperty
	a_vec: assert property (p_vec) else $error("wrong vector");
	property p_trap; trap == (overflow_flag_trap | underflow_trap | precision_trap); endproperty
	a_trap: assert property (p_trap) else $error("trap not or of causes");
	property p_ot;
		overflow_flag_trap |-> overflow_flag
			&& !$past(simd_fp_control_status_reg[sfx_pkg::SFX_OM_BIT]);
	endproperty
	a_ot: assert property (p_ot) else $error("bad overflow trap");
	property p_ut;
		underflow_trap |-> underflow_flag
			&& !$past(simd_fp_control_status_reg[sfx_pkg::SFX_UM_BIT]);
	endproperty
	a_ut: assert property (p_ut) else $error("bad underflow trap");
	property p_pt;
		precision_trap |-> precision_flag && !overflow_flag_trap && !underflow_trap;
	endproperty
	a_pt: assert property (p_pt) else $error("bad precision trap");
	property p_pm;
		precision_trap |-> !$past(simd_fp_control_status_reg[sfx_pkg::SFX_PM_BIT]);
	endproperty
	a_pm: assert property (p_pm) else $error("precision trap while masked");
	property p_om; overflow_flag && !overflow_flag_trap |-> precision_flag; endproperty
	a_om: assert property (p_om) else $error("masked overflow lacks precision");
	property p_um; underflow_flag && !underflow_trap |-> precision_flag; endproperty
	a_um: assert property (p_um) else $error("masked underflow lacks precision");
endmodule : sfx_post_exc_asserts
bind sfx_post_exc sfx_post_exc_asserts chk (.*);

// File: dv/sfx_pipe_model.sv
// Purpose: execution pipeline feeding rounded lane results
// Assumes: requests launched 1 ns after the clock edge
// Notes: lane inputs scrambled while idle
`timescale 1ns/1ps
module sfx_pipe_model (
	input  wire logic        core_clk,
	output logic             in_valid,
	output logic             is_double,
	output logic [3:0]       lane_active,
	output logic [3:0]       lane_sign,
	output logic [3:0]       lane_inexact,
	output logic [3:0][12:0] lane_exp,
	output logic [3:0][51:0] lane_frac,
	output logic [3:0][63:0] lane_bounded,
	output logic [31:0]      ctl
);
	// lsb of a single fraction, so packing slips show up
	localparam logic [51:0] FRAC = 52'h0_0000_2000_0000;
	initial begin
		{in_valid, is_double, lane_active, lane_sign, lane_inexact} = '0;
		{lane_exp, lane_frac, lane_bounded, ctl} = '0;
	end
	task issue(input logic d, input logic [3:0] a, input logic s, input logic [12:0] e,
		input logic ix, input logic [31:0] c);
		@(posedge core_clk);
		#1;
		{in_valid, is_double, lane_active, lane_sign, lane_inexact, lane_exp, ctl} =
			{1'b1, d, a, {4{s}}, {4{ix}}, {4{e}}, c};
		lane_frac    = {4{FRAC}};
		lane_bounded = {4{64'h0000_0000_0040_0000}};
		@(posedge core_clk);
		#1;
		in_valid = 1'b0;
		// released lanes no longer hold their values
		{lane_sign, lane_inexact, lane_exp} = ~{lane_sign, lane_inexact, lane_exp};
		{lane_frac, lane_bounded}           = ~{lane_frac, lane_bounded};
	endtask : issue
endmodule : sfx_pipe_model

// File: dv/sfx_post_exc_tb.sv
// Purpose: self-checking bench for sfx_post_exc
// Assumes: lane 0 carries the scalar result, other lanes pass bounded value, except in the all-lane overflow and double checks
// Notes: trap and vector compared at every check, causes also watched by the bound checker
`timescale 1ns/1ps
module sfx_post_exc_tb;
	localparam logic [31:0] MSK = 32'h0000_1F80;
	localparam logic [31:0] B = 32'h0040_0000;
	localparam logic [7:0][31:0] OVR = {32'hFF7F_FFFF, 32'h7F7F_FFFF, 32'hFF7F_FFFF, 32'h7F80_0000,
		32'hFF80_0000, 32'h7F7F_FFFF, 32'hFF80_0000, 32'h7F80_0000};
	logic             core_clk, nrst, in_valid, is_double, out_valid, trap;
	logic [3:0]       act, sgn, inx, spc;
	logic [3:0][12:0] lexp;
	logic [3:0][51:0] frc;
	logic [3:0][63:0] bnd;
	logic [31:0]      ctl;
	logic [127:0]     res;
	logic [5:0]       flg;
	logic [7:0]       vec;
	int               n_errors, compares;
	sfx_pipe_model pm (
		.core_clk     (core_clk),
		.in_valid     (in_valid),
		.is_double    (is_double),
		.lane_active  (act),
		.lane_sign    (sgn),
		.lane_inexact (inx),
		.lane_exp     (lexp),
		.lane_frac    (frc),
		.lane_bounded (bnd),
		.ctl          (ctl)
	);
	sfx_post_exc dut (
		.core_clk                   (core_clk),
		.nrst                       (nrst),
		.in_valid                   (in_valid),
		.is_double                  (is_double),
		.lane_active                (act),
		.lane_special               (spc),
		.lane_sign                  (sgn),
		.lane_exp                   (lexp),
		.lane_frac                  (frc),
		.lane_inexact               (inx),
		.lane_bounded               (bnd),
		.lane_bounded_inexact       (inx),
		.simd_fp_control_status_reg (ctl),
		.out_valid                  (out_valid),
		.out_result                 (res),
		.overflow_flag              (flg[5]),
		.underflow_flag             (flg[4]),
		.precision_flag             (flg[3]),
		.overflow_flag_trap         (flg[2]),
		.underflow_trap             (flg[1]),
		.precision_trap             (flg[0]),
		.trap                       (trap),
		.trap_vector                (vec)
	);
	task chk(input logic [127:0] er, input logic [5:0] ef);
		logic       et;
		logic [7:0] ev;
		et = |ef[2:0];
		ev = et ? sfx_pkg::SFX_TRAP_VECTOR : 8'h00;
		compares++;
		if ({out_valid, res, flg, trap, vec} !== {1'b1, er, ef, et, ev}) begin
			n_errors++;
			$display("unexpected at %0t: got %h exp %h", $time,
				{res, flg, trap, vec}, {er, ef, et, ev});
		end
	endtask : chk
	task print_verdict;
		if (n_errors == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : print_verdict
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	initial begin
		#20000;
		n_errors++;
		print_verdict();
	end
	initial begin
		n_errors = 0;
		compares = 0;
		spc = 4'h0;
		nrst = 1'b0;
		repeat (6) @(posedge core_clk);
		#1;
		nrst = 1'b1;
		pm.issue(0, 4'h1, 0, 13'h0000, 1, MSK);
		chk({{3{B}}, 32'h3F80_0001}, 6'b001_000);
		pm.issue(0, 4'h1, 0, 13'h0000, 1, MSK ^ 32'h0000_1000);
		chk({{3{B}}, 32'h3F80_0001}, 6'b001_001);
		pm.issue(0, 4'h1, 0, 13'h007F, 0, MSK);
		chk({{3{B}}, 32'h7F00_0001}, 6'b000_000);
		for (int m = 0; m < 8; m++) begin
			pm.issue(0, 4'h1, m[0], 13'h0080, 0,
				MSK | (32'(m[2:1]) << sfx_pkg::SFX_RC_LSB));
			chk({{3{B}}, OVR[m]}, 6'b101_000);
		end
		pm.issue(0, 4'h1, 0, 13'h0080, 0, MSK ^ 32'h0000_0400);
		chk({{3{B}}, 32'h1F80_0001}, 6'b100_100);
		pm.issue(0, 4'h1, 0, 13'h0080, 1, MSK ^ 32'h0000_1000);
		chk({{3{B}}, 32'h7F80_0000}, 6'b101_001);
		pm.issue(0, 4'h1, 0, 13'h1F82, 0, MSK);
		chk({{3{B}}, 32'h0080_0001}, 6'b000_000);
		pm.issue(0, 4'h1, 0, 13'h1F81, 0, MSK);
		chk({4{B}}, 6'b000_000);
		pm.issue(0, 4'h1, 0, 13'h1F81, 1, MSK ^ 32'h0000_1000);
		chk({4{B}}, 6'b011_001);
		pm.issue(0, 4'h1, 0, 13'h1F81, 1, MSK ^ 32'h0000_1800);
		chk({{3{B}}, 32'h6000_0001}, 6'b011_010);
		pm.issue(0, 4'hF, 0, 13'h0080, 0, MSK);
		chk({4{32'h7F80_0000}}, 6'b101_000);
		spc = 4'h1;
		pm.issue(0, 4'h1, 0, 13'h0080, 1, MSK);
		chk({4{B}}, 6'b001_000);
		spc = 4'h0;
		pm.issue(1, 4'h3, 1, 13'h0400, 0, MSK ^ 32'h0000_0400);
		chk({2{64'h9FF0_0000_2000_0000}}, 6'b100_100);
		print_verdict();
	end
endmodule : sfx_post_exc_tb
